// ===== srac_pkg.sv
// Purpose : Constants, decode functions and the small register store module
// Assumes : Command words arrive on the same clock as the decoder
// Notes   : Store index is the low six bits of a register's read code
package srac_pkg;
  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_OVERRIDE = 8'h80;
  localparam logic [7:0] RD_PRE_BASE  = 8'hc0;
  localparam logic [7:0] RD_MAIN_BASE = 8'hd0;
  localparam logic [7:0] CNT3_CODE    = 8'he5;
  localparam logic [7:0] WR_GEN_OFS   = 8'h70;
  localparam logic [7:0] WR_MAIN_OFS  = 8'h40;
  localparam logic [7:0] WR_PRE_OFS   = 8'h10;
  localparam logic [1:0] RK_NONE      = 2'h0;
  localparam logic [1:0] RK_STORE     = 2'h1;
  localparam logic [1:0] RK_EXT       = 2'h2;
  localparam int         RD_LATENCY   = 3;
  localparam int         STORE_DEPTH  = 64;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WR_LO, ST_WR_HI, ST_RD_ADDR, ST_RD_DATA, ST_RD_LO, ST_RD_HI
  } srac_state_type;

  // ---------------------------------------------------------------------------
  // Write code to target read code, bit 8 marks a defined code
  // ---------------------------------------------------------------------------
  function automatic logic [8:0] srac_wr_map(input logic [7:0] c);
    logic [8:0] r;
    r = 9'h000;
    if (c == CMD_OVERRIDE) begin
      r = {1'b1, RD_MAIN_BASE};
    end else if ((c >= 8'h87 && c <= 8'h8a) || (c >= 8'h8c && c <= 8'h8f)) begin
      r = {1'b1, 8'(c + WR_GEN_OFS)};
    end else if ((c >= 8'h90 && c <= 8'ha1) || (c >= 8'ha3 && c <= 8'ha5) ||
                 (c >= 8'ha7 && c <= 8'ha9) || (c >= 8'hab && c <= 8'hae)) begin
      r = {1'b1, 8'(c + WR_MAIN_OFS)};
    end else if (c >= 8'hb0 && c <= 8'hbe) begin
      r = {1'b1, 8'(c + WR_PRE_OFS)};
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Read code kind: stored here, held outside, or undefined
  // ---------------------------------------------------------------------------
  function automatic logic [1:0] srac_rd_kind(input logic [7:0] c);
    logic [1:0] k;
    k = RK_STORE;
    if (c < RD_PRE_BASE || c == 8'he2 || c == 8'he6 || c == 8'hea || c == 8'hf0) begin
      k = RK_NONE;
    end else if (c == 8'hcf || (c >= 8'hed && c <= 8'hef) || c == 8'hf1 ||
                 (c >= 8'hf4 && c <= 8'hf6) || c == 8'hfb) begin
      k = RK_EXT;
    end
    return k;
  endfunction

  // ---------------------------------------------------------------------------
  // Effective bit mask of a register by read code
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] srac_mask(input logic [7:0] c);
    logic [5:0] w;
    w = 6'd28;
    case (c)
      8'hd5: w = 6'd11;
      8'hc3, 8'hc4, 8'hc9, 8'hca, 8'hd3, 8'hd4, 8'hd9, 8'hda, 8'he5: w = 6'd16;
      8'hc1, 8'hc2, 8'hd1, 8'hd2, 8'hdb, 8'hec, 8'hef, 8'hf3: w = 6'd17;
      8'hf2: w = 6'd23;
      8'hc6, 8'hcf, 8'hd6, 8'hf6: w = 6'd24;
      8'hf5: w = 6'd27;
      8'hdd: w = 6'd29;
      8'hc7, 8'hcc, 8'hd7, 8'hde, 8'hfb, 8'hfc: w = 6'd31;
      8'hc5, 8'hdc, 8'hdf, 8'he0, 8'he1, 8'hf1, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hff: w = 6'd32;
      default: w = 6'd28;
    endcase
    if (w == 6'd32) begin
      return 32'hffffffff;
    end
    return 32'((64'h1 << w) - 64'h1);
  endfunction
endpackage

`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Register and pre-register store
// -----------------------------------------------------------------------------
module srac_reg_store (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [5:0]  raddr_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [srac_pkg::STORE_DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < srac_pkg::STORE_DEPTH; i++) begin
        mem[i] <= 32'h00000000;
      end
      rdata_o <= 32'h00000000;
    end else begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// ===== srac_cmd_decoder.sv
// Purpose : Serial command word decoder for register writes and reads
// Assumes : Words come from link logic on sys_clk_i, one per valid cycle
// Notes   : Summary of operation below
// Summary of operation
// - Write command is code, low half, high half; answered by a bare response.
// - Code 80h overrides the positioning amount, flagged apart from 90h.
// - Codes 90h to 9Bh write the twelve motion registers in order.
// - Codes 9Ch to A1h write environment settings one to six.
// - A3h-A5h counters, A7h-A9h comparators, ACh event interrupt enable.
// - ADh and AEh write error and event interrupt status.
// - 87h-8Ah general registers, 8Fh and ABh sync controls.
// - 8Ch, 8Dh, 8Eh write step count, second axis amount and centre.
// - B0h to BEh write pre-registers, BBh stages comparator three.
// - Read is one word; C0h-CEh pre-registers, D0h-FFh main registers.
// - Codes E9h to FFh read the listed compare, status and monitor registers.
// - Read answer echoes code, then low half, then high half.
`timescale 1ns/100ps
`default_nettype none
module srac_cmd_decoder (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        word_valid_i,
  input  wire logic [15:0] word_i,
  output logic             word_ready_o,
  output logic             wr_en_o,
  output logic      [7:0]  wr_addr_o,
  output logic      [31:0] wr_data_o,
  output logic             wr_pre_o,
  output logic             wr_override_o,
  output logic             resp_done_o,
  output logic             resp_valid_o,
  output logic      [15:0] resp_word_o,
  output logic             resp_last_o,
  output logic      [7:0]  ext_rd_code_o,
  input  wire logic [31:0] ext_rd_data_i
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  srac_pkg::srac_state_type state;
  srac_pkg::srac_state_type next_state;
  logic [7:0]  cmd;
  logic [7:0]  next_cmd;
  logic [7:0]  tgt;
  logic [7:0]  next_tgt;
  logic [15:0] lo;
  logic [15:0] next_lo;
  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  logic        next_word_ready;
  logic        next_wr_en;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_wr_data;
  logic        next_wr_pre;
  logic        next_wr_override;
  logic        next_resp_done;
  logic        next_resp_valid;
  logic [15:0] next_resp_word;
  logic        next_resp_last;
  logic [31:0] store_rdata;
  logic        take;
  logic [8:0]  wmap;
  logic [31:0] raw;

  assign take = word_valid_i && word_ready_o;
  assign wmap = srac_pkg::srac_wr_map(word_i[7:0]);
  assign raw  = (srac_pkg::srac_rd_kind(cmd) == srac_pkg::RK_EXT) ? ext_rd_data_i : store_rdata;

  srac_reg_store u_store (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .we_i      (wr_en_o),
    .waddr_i   (wr_addr_o[5:0]),
    .wdata_i   (wr_data_o),
    .raddr_i   (cmd[5:0]),
    .rdata_o   (store_rdata)
  );

  // ---------------------------------------------------------------------------
  // Next state and outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_cmd         = cmd;
    next_tgt         = tgt;
    next_lo          = lo;
    next_rd_data     = rd_data;
    next_wr_en       = 1'b0;
    next_wr_addr     = wr_addr_o;
    next_wr_data     = wr_data_o;
    next_wr_pre      = wr_pre_o;
    next_wr_override = wr_override_o;
    next_resp_done   = 1'b0;
    next_resp_valid  = 1'b0;
    next_resp_word   = 16'h0000;
    next_resp_last   = 1'b0;
    case (state)
      srac_pkg::ST_IDLE: begin
        if (take && word_i[15:8] == 8'h00) begin
          if (wmap[8]) begin
            next_cmd   = word_i[7:0];
            next_tgt   = wmap[7:0];
            next_state = srac_pkg::ST_WR_LO;
          end else if (srac_pkg::srac_rd_kind(word_i[7:0]) != srac_pkg::RK_NONE) begin
            next_cmd   = word_i[7:0];
            next_state = srac_pkg::ST_RD_ADDR;
          end
          // Anything else is dropped without effect
        end
      end
      srac_pkg::ST_WR_LO: begin
        if (take) begin
          next_lo    = word_i;
          next_state = srac_pkg::ST_WR_HI;
        end
      end
      srac_pkg::ST_WR_HI: begin
        if (take) begin
          next_wr_en       = 1'b1;
          next_wr_addr     = tgt;
          next_wr_data     = {word_i, lo} & srac_pkg::srac_mask(tgt);
          next_wr_pre      = tgt < srac_pkg::RD_MAIN_BASE;
          next_wr_override = cmd == srac_pkg::CMD_OVERRIDE;
          next_resp_done   = 1'b1;
          next_state       = srac_pkg::ST_IDLE;
        end
      end
      srac_pkg::ST_RD_ADDR: begin
        next_state = srac_pkg::ST_RD_DATA;
      end
      srac_pkg::ST_RD_DATA: begin
        if (cmd == srac_pkg::CNT3_CODE) begin
          next_rd_data = {{16{raw[15]}}, raw[15:0]};
        end else begin
          next_rd_data = raw & srac_pkg::srac_mask(cmd);
        end
        next_resp_valid = 1'b1;
        next_resp_word  = {8'h00, cmd};
        next_state      = srac_pkg::ST_RD_LO;
      end
      srac_pkg::ST_RD_LO: begin
        next_resp_valid = 1'b1;
        next_resp_word  = rd_data[15:0];
        next_state      = srac_pkg::ST_RD_HI;
      end
      srac_pkg::ST_RD_HI: begin
        next_resp_valid = 1'b1;
        next_resp_word  = rd_data[31:16];
        next_resp_last  = 1'b1;
        next_state      = srac_pkg::ST_IDLE;
      end
      default: begin
        next_state = srac_pkg::ST_IDLE;
      end
    endcase
    next_word_ready = next_state == srac_pkg::ST_IDLE || next_state == srac_pkg::ST_WR_LO ||
                      next_state == srac_pkg::ST_WR_HI;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state         <= srac_pkg::ST_IDLE;
      cmd           <= 8'h00;
      tgt           <= 8'h00;
      lo            <= 16'h0000;
      rd_data       <= 32'h00000000;
      word_ready_o  <= 1'b0;
      wr_en_o       <= 1'b0;
      wr_addr_o     <= 8'h00;
      wr_data_o     <= 32'h00000000;
      wr_pre_o      <= 1'b0;
      wr_override_o <= 1'b0;
      resp_done_o   <= 1'b0;
      resp_valid_o  <= 1'b0;
      resp_word_o   <= 16'h0000;
      resp_last_o   <= 1'b0;
      ext_rd_code_o <= 8'h00;
    end else begin
      state         <= next_state;
      cmd           <= next_cmd;
      tgt           <= next_tgt;
      lo            <= next_lo;
      rd_data       <= next_rd_data;
      word_ready_o  <= next_word_ready;
      wr_en_o       <= next_wr_en;
      wr_addr_o     <= next_wr_addr;
      wr_data_o     <= next_wr_data;
      wr_pre_o      <= next_wr_pre;
      wr_override_o <= next_wr_override;
      resp_done_o   <= next_resp_done;
      resp_valid_o  <= next_resp_valid;
      resp_word_o   <= next_resp_word;
      resp_last_o   <= next_resp_last;
      ext_rd_code_o <= next_cmd;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_write_bare_resp: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_o |-> resp_done_o && !resp_valid_o && $past(state) == srac_pkg::ST_WR_HI)
    else $error("write without bare response");
  a_override_target: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_override_o && wr_en_o |-> wr_addr_o == 8'hd0 && cmd == 8'h80)
    else $error("override went to wrong register");
  a_main_map: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_o && cmd >= 8'h90 && cmd <= 8'h9b |-> wr_addr_o == 8'(cmd + 8'h40) && !wr_pre_o)
    else $error("motion register write misrouted");
  a_env_map: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_o && cmd >= 8'h9c && cmd <= 8'ha1 |-> wr_addr_o >= 8'hdc && wr_addr_o <= 8'he1)
    else $error("environment write misrouted");
  a_pre_map: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_o && cmd >= 8'hb0 |-> wr_pre_o && wr_addr_o == 8'(cmd + 8'h10))
    else $error("pre-register write misrouted");
  a_gen_map: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_o && cmd >= 8'h87 && cmd <= 8'h8f |-> wr_addr_o == 8'(cmd + 8'h70))
    else $error("general or sync write misrouted");
  a_read_frame: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    take && state == srac_pkg::ST_IDLE && word_i[15:6] == 10'h003 &&
    srac_pkg::srac_rd_kind(word_i[7:0]) != srac_pkg::RK_NONE
    |-> ##3 resp_valid_o && resp_word_o == $past(word_i, 3) ##1 resp_valid_o
        ##1 resp_valid_o && resp_last_o)
    else $error("read answer frame wrong");
  a_sign_extend: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    resp_last_o && cmd == 8'he5 |-> resp_word_o == {16{rd_data[15]}})
    else $error("counter three not sign extended");
  a_narrow_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en_o |-> (wr_data_o & ~srac_pkg::srac_mask(wr_addr_o)) == 32'h00000000)
    else $error("bits above register width set");
  a_undef_ignored: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    take && state == srac_pkg::ST_IDLE && word_i == 16'h00a2 |=> state == srac_pkg::ST_IDLE
    ##1 !wr_en_o)
    else $error("undefined code acted on");
  a_busy_reads: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state == srac_pkg::ST_RD_ADDR |-> !word_ready_o [*3])
    else $error("words accepted while answering");
endmodule
`default_nettype wire

// ===== srac_host_model.sv
// Purpose : Central controller stand-in feeding command words
// Assumes : Words change only at the falling clock edge
// Notes   : Idle bus shows the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module srac_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic        word_ready_i,
  input  wire logic [7:0]  ext_rd_code_i,
  output logic             word_valid_o,
  output logic      [15:0] word_o,
  output logic      [31:0] ext_rd_data_o
);
  int timeouts;

  initial begin
    word_valid_o = 1'b0;
    word_o       = 16'h0000;
    timeouts     = 0;
  end

  // Monitor values held outside the decoder
  assign ext_rd_data_o = {ext_rd_code_i, ~ext_rd_code_i, 8'h5a, ext_rd_code_i};

  // One word, held until taken
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    word_valid_o = 1'b1;
    word_o       = w;
    while (word_ready_i !== 1'b1 && n < 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 50) begin
      timeouts++;
    end
    @(posedge sys_clk_i);
  endtask

  task automatic release_bus();
    @(negedge sys_clk_i);
    word_valid_o = 1'b0;
    word_o       = ~word_o;
  endtask
endmodule
`default_nettype wire

// ===== test_serial_register_access_commands.sv
// Purpose : Self-checking bench for the command decoder
// Assumes : Model store mirrors every defined register
// Notes   : Sweeps all write codes, then all read codes
`timescale 1ns/100ps
`default_nettype none
module test_serial_register_access_commands;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic        word_valid_i;
  logic [15:0] word_i;
  logic        word_ready_o;
  logic        wr_en_o;
  logic [7:0]  wr_addr_o;
  logic [31:0] wr_data_o;
  logic        wr_pre_o;
  logic        wr_override_o;
  logic        resp_done_o;
  logic        resp_valid_o;
  logic [15:0] resp_word_o;
  logic        resp_last_o;
  logic [7:0]  ext_rd_code_o;
  logic [31:0] ext_rd_data_i;
  logic [31:0] mem [256];
  logic [43:0] wq [$];
  logic [17:0] rq [$];
  logic [31:0] seed;
  int          num_errors;
  int          compares;

  srac_cmd_decoder srac_cmd_decoder_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .word_valid_i(word_valid_i), .word_i(word_i), .word_ready_o(word_ready_o),
    .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_pre_o(wr_pre_o),
    .wr_override_o(wr_override_o), .resp_done_o(resp_done_o),
    .resp_valid_o(resp_valid_o), .resp_word_o(resp_word_o), .resp_last_o(resp_last_o),
    .ext_rd_code_o(ext_rd_code_o), .ext_rd_data_i(ext_rd_data_i));

  srac_host_model srac_host_model_inst (.sys_clk_i(sys_clk_i),
    .word_ready_i(word_ready_o), .ext_rd_code_i(ext_rd_code_o),
    .word_valid_o(word_valid_i), .word_o(word_i), .ext_rd_data_o(ext_rd_data_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // ---------------------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int wd(input logic [7:0] c);
    case (c)
      8'hd5: return 11;
      8'hc3, 8'hc4, 8'hc9, 8'hca, 8'hd3, 8'hd4, 8'hd9, 8'hda, 8'he5: return 16;
      8'hc1, 8'hc2, 8'hd1, 8'hd2, 8'hdb, 8'hec, 8'hef, 8'hf3: return 17;
      8'hf2: return 23;
      8'hc6, 8'hcf, 8'hd6, 8'hf6: return 24;
      8'hf5: return 27;
      8'hdd: return 29;
      8'hc7, 8'hcc, 8'hd7, 8'hde, 8'hfb, 8'hfc: return 31;
      8'hc5, 8'hdc, 8'hdf, 8'he0, 8'he1, 8'hf1, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hff: return 32;
      default: return 28;
    endcase
  endfunction

  function automatic logic [31:0] mk(input logic [7:0] c);
    return (wd(c) == 32) ? 32'hffffffff : 32'((64'h1 << wd(c)) - 64'h1);
  endfunction

  function automatic logic [7:0] tgt(input logic [7:0] c);
    if (c == 8'h80) return 8'hd0;
    if (c inside {[8'h87:8'h8a], [8'h8c:8'h8f]}) return 8'(c + 8'h70);
    if (c inside {[8'h90:8'ha1], [8'ha3:8'ha5], [8'ha7:8'ha9], [8'hab:8'hae]}) begin
      return 8'(c + 8'h40);
    end
    if (c inside {[8'hb0:8'hbe]}) return 8'(c + 8'h10);
    return 8'h00;
  endfunction

  // ---------------------------------------------------------------------------
  // Drivers and checks
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_wr(input logic [43:0] got, input logic [43:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [15:0] w);
    srac_host_model_inst.send(w);
    if (srac_host_model_inst.timeouts != 0) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] c);
    logic [7:0]  t;
    logic [31:0] d;
    t = tgt(c);
    d = xs();
    if (wd(t) <= 16) d[31:16] = 16'h0000;
    if (t == 8'h00) d = d | 32'h80008000;
    put({8'h00, c});
    put(d[15:0]);
    put(d[31:16]);
    if (t != 8'h00) begin
      d = d & mk(t);
      mem[t] = d;
      wq.push_back({2'b11, t, d, t < 8'hd0, c == 8'h80});
    end
  endtask

  task automatic rd(input logic [7:0] c);
    logic [31:0] d;
    put({8'h00, c});
    if (c inside {8'he2, 8'he6, 8'hea, 8'hf0}) return;
    d = mem[c];
    if (c inside {8'hcf, [8'hed:8'hef], 8'hf1, [8'hf4:8'hf6], 8'hfb}) begin
      d = {c, ~c, 8'h5a, c};
    end
    d = d & mk(c);
    if (c == 8'he5) d[31:16] = {16{d[15]}};
    rq.push_back({2'b10, 8'h00, c});
    rq.push_back({2'b10, d[15:0]});
    rq.push_back({2'b11, d[31:16]});
  endtask

  always @(negedge sys_clk_i) begin
    if (rst_n_i === 1'b1 && (wr_en_o !== 1'b0 || resp_done_o !== 1'b0)) begin
      chk_wr({wr_en_o, resp_done_o, wr_addr_o, wr_data_o, wr_pre_o, wr_override_o},
        (wq.size() != 0) ? wq.pop_front() : 44'h0);
    end
    if (rst_n_i === 1'b1 && resp_valid_o !== 1'b0) begin
      chk_rsp({resp_valid_o, resp_last_o, resp_word_o},
        (rq.size() != 0) ? rq.pop_front() : 18'h0);
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n_i    = 1'b0;
    seed       = 32'd46274;
    num_errors = 0;
    compares   = 0;
    foreach (mem[i]) mem[i] = 32'h00000000;
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    for (int c = 8'h80; c <= 8'hbf; c++) wr(8'(c));
    for (int c = 8'hc0; c <= 8'hff; c++) rd(8'(c));
    put(16'h01d0);
    wr(8'ha5);
    rd(8'he5);
    wr(8'h80);
    rd(8'hd0);
    srac_host_model_inst.release_bus();
    for (int n = 0; n < 40 && (wq.size() + rq.size()) != 0; n++) @(negedge sys_clk_i);
    if ((wq.size() + rq.size()) != 0) num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
